// file: include/uart_chan_pkg.sv
// Register map, field layout and timing constants for one serial channel
package uart_chan_pkg;
  // Clock and power-up line settings
  localparam int CLK_HZ = 25_000_000;
  localparam int DEF_BAUD = 9600;
  localparam logic [15:0] DIV_RESET = 16'(CLK_HZ / DEF_BAUD);
  localparam logic [31:0] RATE_RESET = 32'(DEF_BAUD);
  localparam logic [31:0] LOW_LAT_BAUD = 32'd46921;
  localparam logic [5:0] IDLE_CHARS = 6'd3;

  // Buffer sizes and bulk packet size
  localparam int TX_DEPTH_DEF = 128;
  localparam int RX_DEPTH_DEF = 384;
  localparam int PKT_MAX_DEF = 64;

  // Register byte offsets
  localparam logic [4:0] ADDR_CTRL = 5'h00;
  localparam logic [4:0] ADDR_FMT = 5'h04;
  localparam logic [4:0] ADDR_DIV = 5'h08;
  localparam logic [4:0] ADDR_MASK = 5'h0c;
  localparam logic [4:0] ADDR_ERR = 5'h10;
  localparam logic [4:0] ADDR_RATE = 5'h14;
  localparam logic [4:0] ADDR_STAT = 5'h18;

  // Control register fields
  localparam int CTRL_CHAN_EN = 0;
  localparam int CTRL_TXF_EN = 1;
  localparam int CTRL_RXF_EN = 2;
  localparam int CTRL_WIDE = 3;
  localparam int CTRL_LOWLAT = 4;
  localparam logic [4:0] CTRL_RESET = 5'h07;

  // Format register fields: data bits, parity mode, two stop bits
  localparam int FMT_BITS_LSB = 0;
  localparam int FMT_PAR_LSB = 4;
  localparam int FMT_STOP2 = 7;
  localparam logic [7:0] FMT_RESET = 8'h08;
  localparam logic [15:0] MASK_RESET = 16'h0000;

  // Parity modes
  localparam logic [2:0] PAR_NONE = 3'h0;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_EVEN = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [2:0] PAR_SPACE = 3'h4;

  // Wide-mode status byte and sticky error flag positions
  localparam int ST_BIT8 = 0;
  localparam int ST_PAR = 1;
  localparam int ST_FRM = 2;
  localparam int ST_OVR = 3;
  localparam int ST_BRK = 4;

  // Status register fields
  localparam int STAT_TXCNT_LSB = 0;
  localparam int STAT_TXIDLE = 8;
  localparam int STAT_RXCNT_LSB = 16;
endpackage : uart_chan_pkg

// file: design/uart_tx_shift.sv
// Transmit shift register with fractional bit timing
`timescale 1ns/1ps
`default_nettype none
module uart_tx_shift
  import uart_chan_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [8:0] loadData,
  input wire logic [3:0] dataBits,
  input wire logic [2:0] parMode,
  input wire logic stop2,
  input wire logic [15:0] divisor,
  input wire logic [15:0] clkMask,
  output logic idle,
  output logic txd
);
  logic [12:0] tx_shift_reg_r;
  logic [3:0] bitsLeft_r;
  logic [3:0] bitIdx_r;
  logic [16:0] baudCnt_r;
  logic [12:0] frame;
  logic [3:0] frameLen;
  logic [8:0] dataMasked;
  logic parEn;
  logic parBit;
  logic [3:0] nextIdx;

  // Build start, data, parity and stop bits
  always_comb begin
    parEn = (parMode != PAR_NONE) && (dataBits != 4'd9);
    dataMasked = loadData & ~(9'h1ff << dataBits);
    unique case (parMode)
      PAR_ODD: parBit = ~^dataMasked;
      PAR_EVEN: parBit = ^dataMasked;
      PAR_MARK: parBit = 1'b1;
      default: parBit = 1'b0;
    endcase
    frame = '1;
    frame[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (i < int'(dataBits)) begin
        frame[i + 1] = dataMasked[i];
      end
    end
    if (parEn) begin
      frame[4'(dataBits + 4'd1)] = parBit;
    end
    frameLen = 4'd2 + dataBits + {3'h0, parEn} + {3'h0, stop2};
    nextIdx = bitIdx_r + 4'd1;
  end

  // Shift one bit per divisor period, mask bit adds one cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift_reg_r <= '1;
      bitsLeft_r <= '0;
      bitIdx_r <= '0;
      baudCnt_r <= '0;
    end else if (bitsLeft_r == 4'd0) begin
      if (load) begin
        tx_shift_reg_r <= frame;
        bitsLeft_r <= frameLen;
        bitIdx_r <= '0;
        baudCnt_r <= {1'b0, divisor} + {16'h0000, clkMask[0]};
      end
    end else if (baudCnt_r <= 17'h00001) begin
      tx_shift_reg_r <= {1'b1, tx_shift_reg_r[12:1]};
      bitsLeft_r <= bitsLeft_r - 4'd1;
      bitIdx_r <= nextIdx;
      baudCnt_r <= {1'b0, divisor} + {16'h0000, clkMask[nextIdx]};
    end else begin
      baudCnt_r <= baudCnt_r - 17'h00001;
    end
  end

  assign idle = (bitsLeft_r == 4'd0);
  assign txd = tx_shift_reg_r[0];
endmodule : uart_tx_shift
`default_nettype wire

// file: design/uart_rx_shift.sv
// Receive shift register with start validation and error detection
`timescale 1ns/1ps
`default_nettype none
module uart_rx_shift
  import uart_chan_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic rxPin,
  input wire logic enable,
  input wire logic [3:0] dataBits,
  input wire logic [2:0] parMode,
  input wire logic [15:0] divisor,
  output logic charValid,
  output logic [8:0] charData,
  output logic parErr,
  output logic frmErr,
  output logic brkDet
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  rx_state_t state_r;
  logic rxMeta_r;
  logic rxSync_r;
  logic [15:0] cnt_r;
  logic [3:0] bitIdx_r;
  logic [9:0] rx_shift_reg_r;
  logic parEn;
  logic [3:0] lastIdx;
  logic [8:0] dataMasked;
  logic parExp;

  // Two-stage pin synchroniser
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxMeta_r <= 1'b1;
      rxSync_r <= 1'b1;
    end else begin
      rxMeta_r <= rxPin;
      rxSync_r <= rxMeta_r;
    end
  end

  // Frame layout and expected parity
  always_comb begin
    parEn = (parMode != PAR_NONE) && (dataBits != 4'd9);
    lastIdx = dataBits - 4'd1 + {3'h0, parEn};
    dataMasked = rx_shift_reg_r[8:0] & ~(9'h1ff << dataBits);
    unique case (parMode)
      PAR_ODD: parExp = ~^dataMasked;
      PAR_EVEN: parExp = ^dataMasked;
      PAR_MARK: parExp = 1'b1;
      default: parExp = 1'b0;
    endcase
  end

  // Sample mid-bit, assemble character, flag errors
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= RX_IDLE;
      cnt_r <= '0;
      bitIdx_r <= '0;
      rx_shift_reg_r <= '0;
      charValid <= 1'b0;
      charData <= '0;
      parErr <= 1'b0;
      frmErr <= 1'b0;
      brkDet <= 1'b0;
    end else begin
      charValid <= 1'b0;
      if (!enable) begin
        state_r <= RX_IDLE;
      end else begin
        unique case (state_r)
          RX_IDLE: begin
            if (!rxSync_r) begin
              state_r <= RX_START;
              cnt_r <= divisor >> 1;
            end
          end
          RX_START: begin
            if (cnt_r != 16'h0000) begin
              cnt_r <= cnt_r - 16'h0001;
            end else if (rxSync_r) begin
              state_r <= RX_IDLE;
            end else begin
              state_r <= RX_DATA;
              cnt_r <= divisor - 16'h0001;
              bitIdx_r <= '0;
              rx_shift_reg_r <= '0;
            end
          end
          RX_DATA: begin
            if (cnt_r != 16'h0000) begin
              cnt_r <= cnt_r - 16'h0001;
            end else begin
              rx_shift_reg_r[bitIdx_r] <= rxSync_r;
              cnt_r <= divisor - 16'h0001;
              if (bitIdx_r == lastIdx) begin
                state_r <= RX_STOP;
              end else begin
                bitIdx_r <= bitIdx_r + 4'd1;
              end
            end
          end
          RX_STOP: begin
            if (cnt_r != 16'h0000) begin
              cnt_r <= cnt_r - 16'h0001;
            end else begin
              state_r <= RX_IDLE;
              charValid <= 1'b1;
              charData <= dataMasked;
              parErr <= parEn && (rx_shift_reg_r[dataBits] != parExp);
              frmErr <= !rxSync_r;
              brkDet <= !rxSync_r && (rx_shift_reg_r == 10'h000);
            end
          end
        endcase
      end
    end
  end
endmodule : uart_rx_shift
`default_nettype wire

// file: design/usb_bridged_uart_channel_datapath.sv
// One serial channel of a USB bridge: FIFOs, framing, bulk release, registers
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - 128-byte transmit FIFO; bulk-out bytes become visible only after valid CRC
// - Next FIFO byte loads into transmit shifter whenever it is idle
// - Character: start bit, data LSB first, optional parity, stop bits
// - 7 or 8 data bits with or without parity, 9 bits without parity
// - 9-bit characters without extended format send ninth bit as zero
// - 9-bit extended: two FIFO bytes, second byte bit 0 is data bit 8
// - 384-byte receive FIFO loaded per character, drained by bulk-in requests
// - Normal format, 7 or 8 bits: store data only, drop all status
// - Normal format, 9 bits: store low eight bits only
// - Extended format, 7 or 8 bits: data byte then status byte
// - Extended 9 bits: status byte carries bit 8, framing, overrun, break
// - Sticky error flags readable, set since the last read
// - Full 64-byte packet answered; fewer bytes may be refused with NAK
// - Fewer than 64 bytes and three idle character times: send all
// - Low-latency bit sends any buffered data on the next request
// - Line rate below 46921 bps sets low-latency automatically; set only when such a rate is written, not at power-up
// - Power-up: 9600 bps, 8 data bits, no parity, one stop bit
// - Bit rate set by divisor and fractional mask registers; the receiver uses the divisor only
// - Enables for the channel and each of its FIFOs
// - Channel configured on its own through its own registers
module usb_bridged_uart_channel_datapath
  import uart_chan_pkg::*;
#(
  parameter int TX_DEPTH = TX_DEPTH_DEF,
  parameter int RX_DEPTH = RX_DEPTH_DEF,
  parameter int PKT_MAX = PKT_MAX_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [4:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  input wire logic outValid,
  input wire logic [7:0] outData,
  input wire logic outEnd,
  input wire logic outCrcOk,
  output logic outReady,
  input wire logic inReq,
  output logic inAccept,
  output logic inNak,
  output logic [6:0] inLen,
  output logic inValid,
  output logic [7:0] inData,
  output logic inLast,
  input wire logic inReady,
  input wire logic rxPin,
  output logic txPin
);
  localparam int TXA = $clog2(TX_DEPTH);
  localparam int RXA = $clog2(RX_DEPTH);
  localparam int RXC = $clog2(RX_DEPTH + 1);

  // Register file state
  logic [4:0] ctrl_r;
  logic [7:0] fmt_r;
  logic [15:0] div_r;
  logic [15:0] mask_r;
  logic [31:0] lineRate_r;
  logic [4:0] errFlags_r;
  logic wbAck_r;
  logic [31:0] wbDatR_r;
  logic [31:0] rdMux;
  logic [31:0] wrMerged;
  logic wbReq;
  logic wbWrite;
  logic wbRead;
  logic [4:0] errSet;
  logic [4:0] errClr;

  // Decoded configuration
  logic chanEn;
  logic txFifoEn;
  logic rxFifoEn;
  logic wideMode;
  logic lowLat;
  logic [3:0] dataBits;
  logic [2:0] parMode;
  logic stop2;
  logic nineBit;
  logic wide9;
  logic [3:0] frameBits;

  // Transmit FIFO
  logic [7:0] txMem [TX_DEPTH];
  logic [TXA:0] txWr_r;
  logic [TXA:0] txCommit_r;
  logic [TXA:0] txRd_r;
  logic [TXA:0] txSpec;
  logic [TXA:0] txAvail;
  logic [1:0] txNeed;
  logic txIdle;
  logic txLoad;
  logic [8:0] txLoadData;
  logic [TXA-1:0] txIdx1;

  // Receive FIFO and character path
  logic [7:0] rxMem [RX_DEPTH];
  logic [RXA-1:0] rxWr_r;
  logic [RXA-1:0] rxRd_r;
  logic [RXC-1:0] rxCnt_r;
  logic [RXC-1:0] rxFree;
  logic [RXC-1:0] rxAdd;
  logic [RXC-1:0] rxSub;
  logic [1:0] rxNeed;
  logic rxStore;
  logic rxDrop;
  logic rxPop;
  logic pendOvr_r;
  logic [7:0] statusByte;
  logic charValid;
  logic [8:0] charData;
  logic parErr;
  logic frmErr;
  logic brkDet;

  // Bulk-in release
  logic [6:0] burstLeft_r;
  logic inValid_r;
  logic [7:0] inData_r;
  logic inLast_r;
  logic inAccept_r;
  logic inNak_r;
  logic [6:0] inLen_r;
  logic inBusy;
  logic dataReady;
  logic [6:0] pktLen;
  logic [21:0] idleCnt_r;
  logic [21:0] idleThr;
  logic idleDone;

  // Merge write data into an old value by byte lane
  function automatic logic [31:0] laneMerge(input logic [31:0] oldVal, input logic [31:0] newVal,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = oldVal;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = newVal[b*8 +: 8];
      end
    end
    return res;
  endfunction : laneMerge

  // Advance a receive FIFO index with wrap at the depth
  function automatic logic [RXA-1:0] rxStep(input logic [RXA-1:0] p, input logic [1:0] k);
    logic [RXA:0] s;
    s = {1'b0, p} + (RXA+1)'(k);
    if (s >= (RXA+1)'(RX_DEPTH)) begin
      s = s - (RXA+1)'(RX_DEPTH);
    end
    return s[RXA-1:0];
  endfunction : rxStep

  // Configuration decode
  always_comb begin
    chanEn = ctrl_r[CTRL_CHAN_EN];
    txFifoEn = ctrl_r[CTRL_TXF_EN];
    rxFifoEn = ctrl_r[CTRL_RXF_EN];
    wideMode = ctrl_r[CTRL_WIDE];
    lowLat = ctrl_r[CTRL_LOWLAT];
    unique case (fmt_r[FMT_BITS_LSB +: 4])
      4'd7: dataBits = 4'd7;
      4'd9: dataBits = 4'd9;
      default: dataBits = 4'd8;
    endcase
    parMode = (dataBits == 4'd9) ? PAR_NONE : fmt_r[FMT_PAR_LSB +: 3];
    stop2 = fmt_r[FMT_STOP2];
    nineBit = (dataBits == 4'd9);
    wide9 = nineBit && wideMode;
    frameBits = 4'd2 + dataBits + {3'h0, parMode != PAR_NONE} + {3'h0, stop2};
  end

  // Wishbone strobes; writes and read-clear act at the acknowledging edge
  assign wbReq = wbCyc && wbStb;
  assign wbWrite = wbReq && wbWe && wbAck_r;
  assign wbRead = wbReq && !wbWe && wbAck_r;
  assign wrMerged = laneMerge(rdMux, wbDatW, wbSel);

  // Read multiplexer, unmapped offsets read zero
  always_comb begin
    rdMux = '0;
    unique case (wbAdr)
      ADDR_CTRL: rdMux[4:0] = ctrl_r;
      ADDR_FMT: rdMux[7:0] = fmt_r;
      ADDR_DIV: rdMux[15:0] = div_r;
      ADDR_MASK: rdMux[15:0] = mask_r;
      ADDR_ERR: rdMux[4:0] = errFlags_r;
      ADDR_RATE: rdMux = lineRate_r;
      ADDR_STAT: begin
        rdMux[STAT_TXCNT_LSB +: 8] = 8'(txSpec);
        rdMux[STAT_TXIDLE] = txIdle;
        rdMux[STAT_RXCNT_LSB +: 9] = 9'(rxCnt_r);
      end
      default: rdMux = '0;
    endcase
  end

  // Acknowledge one cycle after the request, read data with it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wbAck_r <= 1'b0;
      wbDatR_r <= '0;
    end else begin
      wbAck_r <= wbReq && !wbAck_r;
      if (wbReq && !wbAck_r) begin
        wbDatR_r <= rdMux;
      end
    end
  end

  assign wbAck = wbAck_r;
  assign wbDatR = wbDatR_r;

  // Configuration registers of this channel
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET;
      fmt_r <= FMT_RESET;
      div_r <= DIV_RESET;
      mask_r <= MASK_RESET;
      lineRate_r <= RATE_RESET;
    end else if (wbWrite) begin
      unique case (wbAdr)
        ADDR_CTRL: ctrl_r <= wrMerged[4:0];
        ADDR_FMT: fmt_r <= wrMerged[7:0];
        ADDR_DIV: div_r <= wrMerged[15:0];
        ADDR_MASK: mask_r <= wrMerged[15:0];
        ADDR_RATE: begin
          lineRate_r <= wrMerged;
          if (wrMerged < LOW_LAT_BAUD) begin
            ctrl_r[CTRL_LOWLAT] <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // Sticky error flags; only reported bits clear, new events win
  always_comb begin
    errSet = '0;
    errSet[ST_PAR] = charValid && parErr;
    errSet[ST_FRM] = charValid && frmErr;
    errSet[ST_OVR] = rxDrop;
    errSet[ST_BRK] = charValid && brkDet;
    errClr = (wbRead && wbAdr == ADDR_ERR) ? wbDatR_r[4:0] : 5'h00;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      errFlags_r <= '0;
    end else begin
      errFlags_r <= (errFlags_r & ~errClr) | errSet;
    end
  end

  // Transmit FIFO occupancy and shifter feed
  always_comb begin
    txSpec = txWr_r - txRd_r;
    txAvail = txCommit_r - txRd_r;
    txNeed = wide9 ? 2'd2 : 2'd1;
    outReady = chanEn && txFifoEn && !outEnd && (txSpec != (TXA+1)'(TX_DEPTH));
    txLoad = chanEn && txIdle && (txAvail >= (TXA+1)'(txNeed));
    txIdx1 = txRd_r[TXA-1:0] + 1'b1;
    if (wide9) begin
      txLoadData = {txMem[txIdx1][0], txMem[txRd_r[TXA-1:0]]};
    end else begin
      txLoadData = {1'b0, txMem[txRd_r[TXA-1:0]]};
    end
  end

  // Packet bytes land speculatively; committed on good CRC, dropped otherwise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txWr_r <= '0;
      txCommit_r <= '0;
      txRd_r <= '0;
    end else if (!txFifoEn) begin
      txWr_r <= '0;
      txCommit_r <= '0;
      txRd_r <= '0;
    end else begin
      if (outValid && outReady) begin
        txWr_r <= txWr_r + 1'b1;
      end
      if (outEnd) begin
        if (outCrcOk) begin
          txCommit_r <= txWr_r;
        end else begin
          txWr_r <= txCommit_r;
        end
      end
      if (txLoad) begin
        txRd_r <= txRd_r + (TXA+1)'(txNeed);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (outValid && outReady) begin
      txMem[txWr_r[TXA-1:0]] <= outData;
    end
  end

  uart_tx_shift txShift (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .load(txLoad),
    .loadData(txLoadData),
    .dataBits(dataBits),
    .parMode(parMode),
    .stop2(stop2),
    .divisor(div_r),
    .clkMask(mask_r),
    .idle(txIdle),
    .txd(txPin)
  );

  uart_rx_shift rxShift (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .rxPin(rxPin),
    .enable(chanEn),
    .dataBits(dataBits),
    .parMode(parMode),
    .divisor(div_r),
    .charValid(charValid),
    .charData(charData),
    .parErr(parErr),
    .frmErr(frmErr),
    .brkDet(brkDet)
  );

  // Receive character store: one byte normally, two in wide mode
  always_comb begin
    rxNeed = wideMode ? 2'd2 : 2'd1;
    rxFree = RXC'(RX_DEPTH) - rxCnt_r;
    rxStore = charValid && chanEn && rxFifoEn && (rxFree >= RXC'(rxNeed));
    rxDrop = charValid && chanEn && rxFifoEn && !rxStore;
    statusByte = '0;
    statusByte[ST_BIT8] = nineBit && charData[8];
    statusByte[ST_PAR] = !nineBit && parErr;
    statusByte[ST_FRM] = frmErr;
    statusByte[ST_OVR] = pendOvr_r;
    statusByte[ST_BRK] = brkDet;
    rxPop = rxFifoEn && (burstLeft_r != 7'd0) && (!inValid_r || inReady);
    rxAdd = rxStore ? RXC'(rxNeed) : '0;
    rxSub = rxPop ? RXC'(1) : '0;
  end

  always_ff @(posedge sys_clk) begin
    if (rxStore) begin
      rxMem[rxWr_r] <= charData[7:0];
      if (wideMode) begin
        rxMem[rxStep(rxWr_r, 2'd1)] <= statusByte;
      end
    end
  end

  // Receive pointers, occupancy and pending overrun for the next status byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxWr_r <= '0;
      rxRd_r <= '0;
      rxCnt_r <= '0;
      pendOvr_r <= 1'b0;
    end else if (!rxFifoEn) begin
      rxWr_r <= '0;
      rxRd_r <= '0;
      rxCnt_r <= '0;
      pendOvr_r <= 1'b0;
    end else begin
      if (rxStore) begin
        rxWr_r <= rxStep(rxWr_r, rxNeed);
      end
      if (rxPop) begin
        rxRd_r <= rxStep(rxRd_r, 2'd1);
      end
      rxCnt_r <= rxCnt_r + rxAdd - rxSub;
      if (rxDrop) begin
        pendOvr_r <= 1'b1;
      end else if (rxStore && wideMode) begin
        pendOvr_r <= 1'b0;
      end
    end
  end

  // Idle time since the last character, three character times
  assign idleThr = div_r * (IDLE_CHARS * {2'b00, frameBits});
  assign idleDone = (idleCnt_r >= idleThr);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      idleCnt_r <= '0;
    end else if (charValid) begin
      idleCnt_r <= '0;
    end else if (!idleDone) begin
      idleCnt_r <= idleCnt_r + 22'h000001;
    end
  end

  // Bulk-in decision
  always_comb begin
    inBusy = (burstLeft_r != 7'd0) || inValid_r;
    pktLen = (rxCnt_r >= RXC'(PKT_MAX)) ? 7'(PKT_MAX) : 7'(rxCnt_r);
    dataReady = chanEn && rxFifoEn &&
                ((rxCnt_r >= RXC'(PKT_MAX)) ||
                 ((rxCnt_r != '0) && (lowLat || idleDone)));
  end

  // Bulk-in answer and byte stream from a registered output stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      burstLeft_r <= '0;
      inValid_r <= 1'b0;
      inData_r <= '0;
      inLast_r <= 1'b0;
      inAccept_r <= 1'b0;
      inNak_r <= 1'b0;
      inLen_r <= '0;
    end else begin
      inAccept_r <= 1'b0;
      inNak_r <= 1'b0;
      if (!rxFifoEn) begin
        burstLeft_r <= '0;
        {inValid_r, inLast_r} <= 2'b00;
      end else if (rxPop) begin
        inData_r <= rxMem[rxRd_r];
        inValid_r <= 1'b1;
        inLast_r <= (burstLeft_r == 7'd1);
        burstLeft_r <= burstLeft_r - 7'd1;
      end else if (inReady) begin
        {inValid_r, inLast_r} <= 2'b00;
      end
      if (inReq) begin
        if (!inBusy && dataReady) begin
          inAccept_r <= 1'b1;
          inLen_r <= pktLen;
          burstLeft_r <= pktLen;
        end else begin
          inNak_r <= 1'b1;
        end
      end
    end
  end

  assign inAccept = inAccept_r;
  assign inNak = inNak_r;
  assign inLen = inLen_r;
  assign inValid = inValid_r;
  assign inData = inData_r;
  assign inLast = inLast_r;
endmodule : usb_bridged_uart_channel_datapath
`default_nettype wire

// file: tb/usb_bridged_uart_channel_datapath_assertions.sv
// Checker on the channel's bus, bulk and serial ports
`timescale 1ns/1ps
`default_nettype none
module uart_chan_chk #(
  parameter int PKT_MAX = 64
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbAck,
  input wire logic inReq,
  input wire logic inAccept,
  input wire logic inNak,
  input wire logic [6:0] inLen,
  input wire logic inValid,
  input wire logic inLast,
  input wire logic outEnd,
  input wire logic outReady,
  input wire logic txPin
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // Bus answer timing
  wb_ack_late_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck) else $error("no ack");
  ack_pulse_a: assert property (wbAck |=> !wbAck) else $error("ack too long");
  // Bulk-in answers and packet shape
  bulk_answer_a: assert property (inReq |=> inAccept ^ inNak) else $error("bad bulk answer");
  in_len_a: assert property (inAccept |-> inLen != 7'd0 && inLen <= PKT_MAX) else $error("bad length");
  first_byte_a: assert property (inAccept |=> inValid) else $error("no first byte");
  last_valid_a: assert property (inLast |-> inValid) else $error("stray last");
  // Commit cycle takes no byte
  commit_hold_a: assert property (outEnd |-> !outReady) else $error("ready on commit");
  // Start bit stays low for at least four cycles
  start_bit_a: assert property ($fell(txPin) |-> !txPin [*4]) else $error("short start");
  cover property (inAccept);
  cover property (inNak);
  cover property ($fell(txPin));
endmodule : uart_chan_chk
bind usb_bridged_uart_channel_datapath uart_chan_chk #(.PKT_MAX(PKT_MAX)) uart_chan_chk_i (.sys_clk, .rst_n,
  .wbCyc, .wbStb, .wbAck, .inReq, .inAccept, .inNak, .inLen, .inValid, .inLast, .outEnd, .outReady, .txPin);
`default_nettype wire

// file: tb/far_uart.sv
// Remote serial end: sends on rxPin, decodes txPin
`timescale 1ns/1ps
`default_nettype none
module far_uart #(
  parameter int BIT = 8
) (
  input wire logic sys_clk,
  input wire logic txPin,
  output var logic rxPin
);
  logic [7:0] gotByte;
  logic gotStop;
  int nGot = 0;
  initial rxPin = 1'b1;
  // One 8N1 character, LSB first
  task send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      rxPin <= f[i];
      repeat (BIT - 1) @(posedge sys_clk);
    end
  endtask : send
  // Mid-bit sampling of nine bits after start
  always begin
    @(negedge txPin);
    repeat (BIT / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(posedge sys_clk);
      if (i < 8) gotByte[i] = txPin;
      else gotStop = txPin;
    end
    nGot++;
  end
endmodule : far_uart
`default_nettype wire

// file: tb/tb_usb_bridged_uart_channel_datapath.sv
// Self-checking bench for one serial channel
`timescale 1ns/1ps
`default_nettype none
module tb_usb_bridged_uart_channel_datapath
  import uart_chan_pkg::*;
();
  typedef struct packed {logic [7:0] fmt; logic [7:0] din; logic [7:0] dout; logic stp;} row_t;
  logic sys_clk = 0, rst_n = 0, wbCyc = 0, wbStb = 0, wbWe = 0, outValid = 0;
  logic outEnd = 0, outCrcOk = 0, inReq = 0, rxPin, txPin, wbAck, outReady;
  logic inAccept, inNak, inValid, inLast;
  logic [4:0] wbAdr = 5'h0;
  logic [31:0] wbDatW = 32'h0, wbDatR, rd;
  logic [7:0] outData = 8'h0, inData;
  logic [6:0] inLen;
  int fails = 0, n_checks = 0, k0;
  // Format, sent byte, decoded byte, bit after the eighth
  row_t rows [7] = '{'{8'h08, 8'h35, 8'h35, 1'b1}, '{8'h07, 8'h35, 8'hb5, 1'b1},
    '{8'h18, 8'h35, 8'h35, 1'b1}, '{8'h28, 8'h35, 8'h35, 1'b0}, '{8'h38, 8'h35, 8'h35, 1'b1},
    '{8'h48, 8'h35, 8'h35, 1'b0}, '{8'h09, 8'h35, 8'h35, 1'b0}};
  usb_bridged_uart_channel_datapath usb_bridged_uart_channel_datapath_i (.sys_clk, .rst_n, .wbCyc, .wbStb,
    .wbWe, .wbAdr, .wbSel(4'hf), .wbDatW, .wbDatR, .wbAck, .outValid, .outData, .outEnd, .outCrcOk, .outReady,
    .inReq, .inAccept, .inNak, .inLen, .inValid, .inData, .inLast, .inReady(1'b1), .rxPin, .txPin);
  far_uart #(.BIT(8)) far_uart_i (.sys_clk, .txPin, .rxPin);
  initial forever #20 sys_clk = ~sys_clk;
  // Hang guard
  initial begin
    repeat (30000) @(posedge sys_clk);
    $display("FAIL %0t: timeout", $time);
    fails++;
    conclude();
  end
  task conclude;
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("FAIL %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Classic single Wishbone cycle
  task wb(input logic we, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatW} <= {2'b11, we, a, d};
    do @(posedge sys_clk); while (wbAck !== 1'b1);
    rd = wbDatR;
    {wbCyc, wbStb, wbWe} <= 3'b000;
  endtask : wb
  // One-byte bulk-out packet, good or bad check
  task pkt(input logic [7:0] d, input logic ok);
    @(posedge sys_clk);
    {outValid, outData} <= {1'b1, d};
    do @(posedge sys_clk); while (outReady !== 1'b1);
    {outValid, outEnd, outCrcOk} <= {2'b01, ok};
    @(posedge sys_clk);
    outEnd <= 1'b0;
  endtask : pkt
  task req;
    @(posedge sys_clk);
    inReq <= 1'b1;
    @(posedge sys_clk);
    inReq <= 1'b0;
    @(posedge sys_clk);
  endtask : req
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    wb(1'b0, ADDR_FMT, 32'h0);
    chk(rd, 32'h08);
    wb(1'b0, ADDR_DIV, 32'h0);
    chk(rd, 32'(DIV_RESET));
    wb(1'b0, 5'h1c, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, ADDR_DIV, 32'h8);
    // Character formats through the far end
    foreach (rows[k]) begin
      wb(1'b1, ADDR_FMT, 32'(rows[k].fmt));
      k0 = far_uart_i.nGot;
      pkt(rows[k].din, 1'b1);
      while (far_uart_i.nGot == k0) @(posedge sys_clk);
      chk(32'({far_uart_i.gotStop, far_uart_i.gotByte}), 32'({rows[k].stp, rows[k].dout}));
      do wb(1'b0, ADDR_STAT, 32'h0); while (rd[STAT_TXIDLE] !== 1'b1);
    end
    // Bad check discards the packet
    wb(1'b1, ADDR_FMT, 32'h8);
    pkt(8'h5a, 1'b0);
    wb(1'b0, ADDR_STAT, 32'h0);
    chk(32'(rd[8:0]), 32'h100);
    chk(32'(txPin), 32'h1);
    // Received byte: refused early, then sent at low rate
    far_uart_i.send(8'h3c);
    do wb(1'b0, ADDR_STAT, 32'h0); while (rd[24:16] === 9'h0);
    req();
    chk(32'(inNak), 32'h1);
    wb(1'b1, ADDR_RATE, 32'd9600);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk(32'(rd[4]), 32'h1);
    req();
    chk(32'({inAccept, inLen}), 32'h81);
    @(posedge sys_clk);
    chk(32'({inValid, inLast, inData}), 32'h33c);
    wb(1'b0, ADDR_ERR, 32'h0);
    chk(rd, 32'h0);
    conclude();
  end
endmodule : tb_usb_bridged_uart_channel_datapath
`default_nettype wire
